// [include/frame_fwd_defs.vh]
// constants shared by the frame forwarding block and its helpers
// assumes byte-wide frame streams and 48-bit destination sidebands
`ifndef FRAME_FWD_DEFS_VH
`define FRAME_FWD_DEFS_VH

`define MAC_W 48
`define BYTE_W 8
`define GROUP_BIT 40
`define BCAST_MAC 48'hffffffffffff
`define HASH_W 6
`define TBL_W 64
`define FIFO_W 9
`define FIFO_DEPTH 8
`define FIFO_AW 3
`define PAT_W 32
`define PAT_LAST 9'h003
`define OFS_W 8
`define CNT_W 16
`define CNT_ONE 16'h0001

`endif

// [hw/frame_fifo.v]
// frame beat fifo with a registered output stage
// assumes the writer checks room2 one cycle ahead; push is also guarded
`timescale 1ns/100ps
`default_nettype none
module frame_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  input wire [WIDTH-1:0] in_data,
  output wire in_ready,
  output reg room2_q,
  output reg out_valid_q,
  output reg [WIDTH-1:0] out_data_q,
  input wire out_ready
);
  localparam [AW:0] FULL_CNT = DEPTH;
  localparam [AW:0] ROOM_CNT = DEPTH - 2;
  localparam [AW:0] ZERO_CNT = 0;
  localparam [AW:0] ONE_CNT = 1;

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  reg [AW:0] cnt_d;
  wire push;
  wire pop;

  assign in_ready = (cnt_q != FULL_CNT);
  assign push = in_valid && in_ready;
  // refill the output stage whenever it is empty or being taken
  assign pop = (cnt_q != ZERO_CNT) && (!out_valid_q || out_ready);

  always @*
  begin
    cnt_d = cnt_q;
    if (push && !pop)
      cnt_d = cnt_q + ONE_CNT;
    else if (pop && !push)
      cnt_d = cnt_q - ONE_CNT;
  end

  always @(posedge clk)
  begin
    if (push)
      mem[wr_q] <= in_data;
  end

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= ZERO_CNT;
      room2_q <= 1'b1;
      out_valid_q <= 1'b0;
      out_data_q <= {WIDTH{1'b0}};
    end
    else
    begin
      if (push)
        wr_q <= wr_q + 1'b1;
      if (pop)
      begin
        rd_q <= rd_q + 1'b1;
        out_data_q <= mem[rd_q];
      end
      out_valid_q <= pop || (out_valid_q && !out_ready);
      cnt_q <= cnt_d;
      room2_q <= (cnt_d <= ROOM_CNT);
    end
  end
endmodule
`default_nettype wire

// [hw/wake_match.v]
// masked 32-bit pattern match at a byte offset within a frame
// assumes one byte per beat and that first marks the frame's opening byte
`timescale 1ns/100ps
`default_nettype none
`include "frame_fwd_defs.vh"
module wake_match (
  input wire clk,
  input wire rst_n,
  input wire beat,
  input wire first,
  input wire for_host,
  input wire [`BYTE_W-1:0] data,
  input wire arm,
  input wire [`PAT_W-1:0] pattern,
  input wire [`PAT_W-1:0] mask,
  input wire [`OFS_W-1:0] offset,
  output reg hit_q
);
  reg [`OFS_W:0] idx_q;
  reg [`PAT_W-1:0] win_q;
  wire [`OFS_W:0] cur_idx;
  wire [`OFS_W:0] end_idx;
  wire [`PAT_W-1:0] win_now;

  assign cur_idx = first ? {(`OFS_W+1){1'b0}} : idx_q;
  assign end_idx = {1'b0, offset} + `PAT_LAST;
  assign win_now = {win_q[`PAT_W-`BYTE_W-1:0], data};

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      idx_q <= {(`OFS_W+1){1'b0}};
      win_q <= {`PAT_W{1'b0}};
      hit_q <= 1'b0;
    end
    else
    begin
      hit_q <= 1'b0;
      if (beat)
      begin
        win_q <= win_now;
        if (!(&cur_idx))
          idx_q <= cur_idx + 1'b1;
        if (arm && for_host && cur_idx == end_idx && (win_now & mask) == (pattern & mask))
          hit_q <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// [hw/frame_fwd.v]
// downstream and upstream frame forwarding between cable side and host side
// assumes all inputs are on CLOCK; destination and permit sidebands are valid with the first beat
`timescale 1ns/100ps
`default_nettype none
`include "frame_fwd_defs.vh"
// What this block does
// - Frames whose destination equals the host address go to the host fifo.
// - Broadcast frames go to the host fifo.
// - Multicast frames go to the host only if the operator table permits their group hash.
// - An optional host table further restricts multicast on top of the operator table.
// - Operator table inputs have no read-back path and the host ports cannot change them.
// - A masked pattern match in a host-bound frame while armed pulls the wake pin low.
// - Frames for the modem address never reach the host fifo.
// - Host frames marked outbound and permitted by the modem filter go to the network fifo.
// - Test and identification requests to the host get no reply from this block.
// - Those requests are forwarded to the host byte for byte like other host unicast.
// - Every stored address and compare is a full 48-bit value.
// - Forwarding is a plain transparent filter with no spanning tree handling.
// - The modem address and the host address are held as two separate values.
// - Unicast frames for any address other than host or modem are withheld.
// - Frames for the modem address are routed to the modem stack fifo.
module frame_fwd (
  input wire CLOCK,
  input wire RSTN,
  input wire [`MAC_W-1:0] MODEM_MAC,
  input wire [`MAC_W-1:0] HOST_MAC,
  input wire [`TBL_W-1:0] OPER_MCAST_TABLE,
  input wire HOST_MCAST_EN,
  input wire [`TBL_W-1:0] HOST_MCAST_TABLE,
  input wire DS_VALID,
  input wire DS_FIRST,
  input wire DS_LAST,
  input wire [`BYTE_W-1:0] DS_DATA,
  input wire [`MAC_W-1:0] DS_DST,
  output reg DS_READY,
  output wire HOST_VALID,
  output wire [`BYTE_W-1:0] HOST_DATA,
  output wire HOST_LAST,
  input wire HOST_READY,
  output wire MODEM_VALID,
  output wire [`BYTE_W-1:0] MODEM_DATA,
  output wire MODEM_LAST,
  input wire MODEM_READY,
  input wire US_VALID,
  input wire US_FIRST,
  input wire US_LAST,
  input wire [`BYTE_W-1:0] US_DATA,
  input wire US_OUTBOUND,
  input wire US_PERMIT,
  output reg US_READY,
  output wire NET_VALID,
  output wire [`BYTE_W-1:0] NET_DATA,
  output wire NET_LAST,
  input wire NET_READY,
  input wire WAKE_ARM,
  input wire [`PAT_W-1:0] WAKE_PATTERN,
  input wire [`PAT_W-1:0] WAKE_MASK,
  input wire [`OFS_W-1:0] WAKE_OFFSET,
  input wire PME_CLEAR,
  output reg PME_N_OUT,
  output reg PME_N_OE,
  output reg [`CNT_W-1:0] HOST_FRAMES,
  output reg [`CNT_W-1:0] MODEM_FRAMES,
  output reg [`CNT_W-1:0] DROP_FRAMES,
  output reg [`CNT_W-1:0] NET_FRAMES
);
  localparam [3:0] S_IDLE = 4'h1;
  localparam [3:0] S_HOST = 4'h2;
  localparam [3:0] S_MODEM = 4'h4;
  localparam [3:0] S_DROP = 4'h8;

  // fold a destination into a group table index
  function [`HASH_W-1:0] group_hash;
    input [`MAC_W-1:0] dst;
    integer i;
    begin
      group_hash = {`HASH_W{1'b0}};
      for (i = 0; i < `MAC_W / `HASH_W; i = i + 1)
        group_hash = group_hash ^ dst[i*`HASH_W +: `HASH_W];
    end
  endfunction

  // pick the route of a frame from its destination
  function [3:0] classify;
    input [`MAC_W-1:0] dst;
    input [`MAC_W-1:0] modem_mac;
    input [`MAC_W-1:0] host_mac;
    input [`TBL_W-1:0] oper_tbl;
    input host_en;
    input [`TBL_W-1:0] host_tbl;
    reg [`HASH_W-1:0] h;
    begin
      h = group_hash(dst);
      if (dst == modem_mac)
        classify = S_MODEM;
      else if (dst == `BCAST_MAC)
        classify = S_HOST;
      else if (dst[`GROUP_BIT])
      begin
        if (oper_tbl[h] && (!host_en || host_tbl[h]))
          classify = S_HOST;
        else
          classify = S_DROP;
      end
      else if (dst == host_mac)
        classify = S_HOST;
      else
        classify = S_DROP;
    end
  endfunction

  reg [3:0] state_q;
  reg [3:0] state_d;
  reg [3:0] route;
  reg us_fwd_q;
  reg us_route;
  reg pme_q;
  wire route_host;
  wire ds_beat;
  wire us_beat;
  wire host_push;
  wire modem_push;
  wire net_push;
  wire host_room;
  wire modem_room;
  wire net_room;
  wire wake_hit;

  assign ds_beat = DS_VALID && DS_READY;
  assign us_beat = US_VALID && US_READY;

  // no bridge protocol frames are treated specially
  always @*
  begin
    route = S_DROP;
    if (DS_FIRST)
      route = classify(DS_DST, MODEM_MAC, HOST_MAC, OPER_MCAST_TABLE,
                       HOST_MCAST_EN, HOST_MCAST_TABLE);
    else
      case (state_q)
        S_HOST: route = S_HOST;
        S_MODEM: route = S_MODEM;
        S_DROP: route = S_DROP;
        S_IDLE: route = S_DROP;
        default: route = S_DROP;
      endcase
  end

  always @*
  begin
    state_d = state_q;
    if (ds_beat)
      state_d = DS_LAST ? S_IDLE : route;
  end

  // one decode shared by the host fifo and the wake matcher
  assign route_host = (route == S_HOST);

  // no reply source exists; host bound bytes only pass through
  assign host_push = ds_beat && route_host;
  // modem bound bytes never enter the host fifo
  assign modem_push = ds_beat && (route == S_MODEM);

  // outbound permitted frames toward the network
  always @*
  begin
    us_route = us_fwd_q;
    if (US_FIRST)
      us_route = US_OUTBOUND && US_PERMIT;
  end

  assign net_push = us_beat && us_route;

  frame_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) host_fifo (
    .clk(CLOCK),
    .rst_n(RSTN),
    .in_valid(host_push),
    .in_data({DS_LAST, DS_DATA}),
    .in_ready(),
    .room2_q(host_room),
    .out_valid_q(HOST_VALID),
    .out_data_q({HOST_LAST, HOST_DATA}),
    .out_ready(HOST_READY)
  );

  frame_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) modem_fifo (
    .clk(CLOCK),
    .rst_n(RSTN),
    .in_valid(modem_push),
    .in_data({DS_LAST, DS_DATA}),
    .in_ready(),
    .room2_q(modem_room),
    .out_valid_q(MODEM_VALID),
    .out_data_q({MODEM_LAST, MODEM_DATA}),
    .out_ready(MODEM_READY)
  );

  frame_fifo #(
    .WIDTH(`FIFO_W),
    .DEPTH(`FIFO_DEPTH),
    .AW(`FIFO_AW)
  ) net_fifo (
    .clk(CLOCK),
    .rst_n(RSTN),
    .in_valid(net_push),
    .in_data({US_LAST, US_DATA}),
    .in_ready(),
    .room2_q(net_room),
    .out_valid_q(NET_VALID),
    .out_data_q({NET_LAST, NET_DATA}),
    .out_ready(NET_READY)
  );

  wake_match wake (
    .clk(CLOCK),
    .rst_n(RSTN),
    .beat(ds_beat),
    .first(DS_FIRST),
    .for_host(route_host),
    .data(DS_DATA),
    .arm(WAKE_ARM),
    .pattern(WAKE_PATTERN),
    .mask(WAKE_MASK),
    .offset(WAKE_OFFSET),
    .hit_q(wake_hit)
  );

  always @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      state_q <= S_IDLE;
      us_fwd_q <= 1'b0;
      DS_READY <= 1'b0;
      US_READY <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      if (us_beat)
        us_fwd_q <= US_LAST ? 1'b0 : us_route;
      // ready one cycle ahead, sized on two free slots
      DS_READY <= host_room && modem_room;
      US_READY <= net_room;
    end
  end

  // wake latch and open-drain pin; the pin lags the latch by one edge
  always @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      pme_q <= 1'b0;
      PME_N_OUT <= 1'b0;
      PME_N_OE <= 1'b0;
    end
    else
    begin
      if (wake_hit)
        pme_q <= 1'b1;
      else if (PME_CLEAR)
        pme_q <= 1'b0;
      // pin is only ever pulled low
      PME_N_OUT <= 1'b0;
      PME_N_OE <= pme_q;
    end
  end

  // frame counters, counted at the first accepted beat
  always @(posedge CLOCK)
  begin
    if (!RSTN)
    begin
      HOST_FRAMES <= {`CNT_W{1'b0}};
      MODEM_FRAMES <= {`CNT_W{1'b0}};
      DROP_FRAMES <= {`CNT_W{1'b0}};
      NET_FRAMES <= {`CNT_W{1'b0}};
    end
    else
    begin
      if (ds_beat && DS_FIRST)
        case (route)
          S_HOST: HOST_FRAMES <= HOST_FRAMES + `CNT_ONE;
          S_MODEM: MODEM_FRAMES <= MODEM_FRAMES + `CNT_ONE;
          S_DROP: DROP_FRAMES <= DROP_FRAMES + `CNT_ONE;
          default: DROP_FRAMES <= DROP_FRAMES;
        endcase
      if (net_push && US_FIRST)
        NET_FRAMES <= NET_FRAMES + `CNT_ONE;
    end
  end
endmodule
`default_nettype wire

// [testbench/host_sink.sv]
// host side sink model for one outgoing byte stream
// assumes the stream is registered on clk; slow takes a byte every fourth cycle
`timescale 1ns/100ps
`default_nettype none
module host_sink (
  input wire logic clk,
  input wire logic slow,
  input wire logic valid,
  input wire logic [7:0] data,
  input wire logic last,
  output logic ready
);
  logic [7:0] got [0:31];
  logic [1:0] ph = 2'h0;
  int n = 0;
  int frames = 0;
  initial ready = 1'h0;
  always @(posedge clk)
  begin
    ph <= ph + 2'h1;
    ready <= !slow || ph == 2'h0;
    if (valid && ready)
    begin
      got[n[4:0]] <= data;
      n <= n + 1;
      frames <= frames + int'(last);
    end
  end
endmodule
`default_nettype wire

// [testbench/frame_fwd_assertions.sv]
// port checker for frame_fwd, bound into every instance
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/100ps
`default_nettype none
`include "frame_fwd_defs.vh"
module frame_fwd_chk (
  input wire logic CLOCK,
  input wire logic RSTN,
  input wire logic [`MAC_W-1:0] MODEM_MAC,
  input wire logic [`MAC_W-1:0] HOST_MAC,
  input wire logic DS_VALID,
  input wire logic DS_FIRST,
  input wire logic DS_READY,
  input wire logic [`MAC_W-1:0] DS_DST,
  input wire logic HOST_VALID,
  input wire logic [`BYTE_W-1:0] HOST_DATA,
  input wire logic HOST_READY,
  input wire logic US_VALID,
  input wire logic US_FIRST,
  input wire logic US_READY,
  input wire logic US_OUTBOUND,
  input wire logic US_PERMIT,
  input wire logic PME_N_OUT,
  input wire logic PME_N_OE,
  input wire logic PME_CLEAR,
  input wire logic [`CNT_W-1:0] HOST_FRAMES,
  input wire logic [`CNT_W-1:0] MODEM_FRAMES,
  input wire logic [`CNT_W-1:0] DROP_FRAMES,
  input wire logic [`CNT_W-1:0] NET_FRAMES
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!RSTN);
  wire logic ds_go = DS_VALID && DS_READY && DS_FIRST;
  wire logic us_go = US_VALID && US_READY && US_FIRST;
  a_modem_kept: assert property (
    ds_go && DS_DST == MODEM_MAC |=> MODEM_FRAMES == $past(MODEM_FRAMES) + `CNT_ONE
    && $stable(HOST_FRAMES)) else $error("modem frame not routed to modem");
  a_host_uni: assert property (
    ds_go && DS_DST == HOST_MAC && DS_DST != MODEM_MAC
    |=> HOST_FRAMES == $past(HOST_FRAMES) + `CNT_ONE) else $error("host frame lost");
  a_bcast_fwd: assert property (
    ds_go && DS_DST == `BCAST_MAC && DS_DST != MODEM_MAC
    |=> HOST_FRAMES == $past(HOST_FRAMES) + `CNT_ONE) else $error("broadcast lost");
  a_uni_drop: assert property (
    ds_go && !DS_DST[`GROUP_BIT] && DS_DST != HOST_MAC && DS_DST != MODEM_MAC
    |=> DROP_FRAMES == $past(DROP_FRAMES) + `CNT_ONE && $stable(HOST_FRAMES))
    else $error("foreign unicast not dropped");
  a_up_block: assert property (
    us_go && !(US_OUTBOUND && US_PERMIT) |=> $stable(NET_FRAMES))
    else $error("blocked upstream frame sent");
  a_up_pass: assert property (
    us_go && US_OUTBOUND && US_PERMIT |=> NET_FRAMES == $past(NET_FRAMES) + `CNT_ONE)
    else $error("outbound frame not sent");
  a_host_hold: assert property (
    HOST_VALID && !HOST_READY |=> HOST_VALID && $stable(HOST_DATA))
    else $error("host byte changed while stalled");
  a_wake_hold: assert property (
    PME_N_OE && !$past(PME_CLEAR) |=> PME_N_OE)
    else $error("wake dropped without clear");
  a_wake_low: assert property (
    PME_N_OE |-> !PME_N_OUT) else $error("wake pin driven high");
endmodule
bind frame_fwd frame_fwd_chk u_chk (.*);
`default_nettype wire

// [testbench/frame_fwd_tb.sv]
// self-checking bench for frame_fwd: routing, back-pressure, upstream gate, wake
// assumes host_sink models on the host, modem and network streams
`timescale 1ns/100ps
`default_nettype none
`include "frame_fwd_defs.vh"
module frame_fwd_tb;
  logic CLOCK = 1'h0;
  logic RSTN = 1'h0;
  logic [47:0] MODEM_MAC = 48'h020000000001;
  logic [47:0] HOST_MAC = 48'h020000000002;
  logic [63:0] OPER_MCAST_TABLE = 64'h0;
  logic [63:0] HOST_MCAST_TABLE = 64'h0;
  logic HOST_MCAST_EN = 1'h0;
  logic DS_VALID = 1'h0, DS_FIRST = 1'h0, DS_LAST = 1'h0;
  logic [7:0] DS_DATA = 8'h0;
  logic [47:0] DS_DST = 48'h0;
  logic US_VALID = 1'h0, US_FIRST = 1'h0, US_LAST = 1'h0;
  logic US_OUTBOUND = 1'h0, US_PERMIT = 1'h0;
  logic [7:0] US_DATA = 8'h0;
  logic WAKE_ARM = 1'h0, PME_CLEAR = 1'h0;
  logic [31:0] WAKE_PATTERN = 32'h0, WAKE_MASK = 32'h0;
  logic [7:0] WAKE_OFFSET = 8'h0;
  wire logic DS_READY, US_READY, HOST_VALID, HOST_LAST, HOST_READY, MODEM_VALID;
  wire logic MODEM_LAST, MODEM_READY, NET_VALID, NET_LAST, NET_READY, PME_N_OUT, PME_N_OE;
  wire logic [7:0] HOST_DATA, MODEM_DATA, NET_DATA;
  wire logic [15:0] HOST_FRAMES, MODEM_FRAMES, DROP_FRAMES, NET_FRAMES;
  // open-drain wake pin with pull-up
  wire logic pme_n = PME_N_OE ? PME_N_OUT : 1'h1;
  logic slow = 1'h0, stalled = 1'h0;
  logic [15:0] e_host = 16'h0, e_modem = 16'h0, e_drop = 16'h0, e_net = 16'h0;
  // multicast group 48'h01.. folds to hash 6'h10, table bit 16
  localparam logic [47:0] MC = 48'h010000000000;
  localparam logic [63:0] T = 64'h10000;
  int miscompares = 0;
  int n_tests = 0;
  frame_fwd u_dut (.*);
  host_sink u_host (.clk(CLOCK), .slow(slow), .valid(HOST_VALID), .data(HOST_DATA),
    .last(HOST_LAST), .ready(HOST_READY));
  host_sink u_modem (.clk(CLOCK), .slow(1'h0), .valid(MODEM_VALID), .data(MODEM_DATA),
    .last(MODEM_LAST), .ready(MODEM_READY));
  host_sink u_net (.clk(CLOCK), .slow(1'h0), .valid(NET_VALID), .data(NET_DATA),
    .last(NET_LAST), .ready(NET_READY));
  initial forever #12.5 CLOCK = ~CLOCK;
  always @(posedge CLOCK) if (DS_VALID && !DS_READY) stalled <= 1'h1;
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      miscompares++;
    end
  endtask
  task chk_counts;
    chk(HOST_FRAMES, e_host);
    chk(MODEM_FRAMES, e_modem);
    chk(DROP_FRAMES, e_drop);
    chk(NET_FRAMES, e_net);
    chk(u_host.frames, e_host);
    chk(u_modem.frames, e_modem);
    chk(u_net.frames, e_net);
  endtask
  task send_ds(input logic [47:0] dst, input int len, input logic [7:0] base);
    for (int i = 0; i < len; i++)
    begin
      DS_VALID <= 1'h1;
      DS_FIRST <= (i == 0);
      DS_LAST <= (i == len - 1);
      DS_DATA <= base + i[7:0];
      DS_DST <= dst;
      @(posedge CLOCK);
      while (DS_READY !== 1'h1) @(posedge CLOCK);
    end
    DS_VALID <= 1'h0;
  endtask
  task send_us(input logic ob, input logic pm, input int len, input logic [7:0] base);
    for (int i = 0; i < len; i++)
    begin
      US_VALID <= 1'h1;
      US_FIRST <= (i == 0);
      US_LAST <= (i == len - 1);
      US_DATA <= base + i[7:0];
      US_OUTBOUND <= ob;
      US_PERMIT <= pm;
      @(posedge CLOCK);
      while (US_READY !== 1'h1) @(posedge CLOCK);
    end
    US_VALID <= 1'h0;
  endtask
  task drain;
    int idle;
    idle = 0;
    for (int k = 0; k < 400 && idle < 4; k++)
    begin
      @(posedge CLOCK);
      idle = (HOST_VALID === 1'h1 || MODEM_VALID === 1'h1 || NET_VALID === 1'h1) ? 0 : idle + 1;
    end
  endtask
  task t_host_bp;
    slow <= 1'h1;
    send_ds(HOST_MAC, 20, 8'h10);
    drain;
    slow <= 1'h0;
    e_host += 16'h1;
    for (int i = 0; i < 20; i++)
      chk(u_host.got[i], 8'h10 + i[7:0]);
    chk(stalled, 1'h1);
    chk_counts;
  endtask
  task one_frame(input logic [47:0] d, input logic [63:0] ot, input logic en,
    input logic [63:0] ht, input logic [1:0] to);
    OPER_MCAST_TABLE <= ot;
    HOST_MCAST_EN <= en;
    HOST_MCAST_TABLE <= ht;
    send_ds(d, 3, 8'h80);
    drain;
    e_host += (to == 2'h0);
    e_modem += (to == 2'h1);
    e_drop += (to == 2'h2);
    chk_counts;
  endtask
  task t_route;
    one_frame(MODEM_MAC, T, 1'h0, 64'h0, 2'h1);
    for (int i = 0; i < 3; i++)
      chk(u_modem.got[i], 8'h80 + i[7:0]);
    one_frame(`BCAST_MAC, 64'h0, 1'h0, 64'h0, 2'h0);
    one_frame(48'h020000000009, T, 1'h0, 64'h0, 2'h2);
    one_frame(MC, T, 1'h0, 64'h0, 2'h0);
    one_frame(48'h030000000000, T, 1'h0, 64'h0, 2'h2);
    one_frame(MC, T, 1'h1, 64'h0, 2'h2);
    one_frame(MC, T, 1'h1, T, 2'h0);
    one_frame(MC, 64'h0, 1'h1, T, 2'h2);
  endtask
  task t_up;
    for (int i = 0; i < 4; i++)
    begin
      send_us(i[1], i[0], 4, 8'hc0);
      drain;
      e_net += (i == 3);
      chk_counts;
    end
    for (int i = 0; i < 4; i++)
      chk(u_net.got[i], 8'hc0 + i[7:0]);
  endtask
  task t_wake;
    WAKE_ARM <= 1'h1;
    WAKE_PATTERN <= 32'h40414243;
    WAKE_MASK <= 32'hffffffff;
    send_ds(HOST_MAC, 6, 8'h50);
    drain;
    chk(pme_n, 1'h1);
    send_ds(HOST_MAC, 6, 8'h40);
    drain;
    chk(pme_n, 1'h0);
    PME_CLEAR <= 1'h1;
    @(posedge CLOCK);
    PME_CLEAR <= 1'h0;
    repeat (2) @(posedge CLOCK);
    chk(pme_n, 1'h1);
    e_host += 16'h2;
    chk_counts;
  endtask
  initial
  begin
    #125000;
    miscompares++;
    end_of_test;
  end
  initial
  begin
    repeat (8) @(posedge CLOCK);
    RSTN <= 1'h1;
    repeat (2) @(posedge CLOCK);
    t_host_bp;
    t_route;
    t_up;
    t_wake;
    end_of_test;
  end
endmodule
`default_nettype wire
